// [bmx_consts.svh]
// named constants for the bridge mode pin multiplexer
`ifndef BMX_CONSTS_SVH
`define BMX_CONSTS_SVH
`define BMX_MODE_ZERO 2'h0
`define BMX_MODE_ONE 2'h1
`define BMX_MODE_TWO 2'h2
`define BMX_MODE_THREE 2'h3
`define BMX_MODE_RST 2'h0
`define BMX_GP_N 4
`define BMX_GP0 0
`define BMX_GP1 1
`define BMX_GP2 2
`define BMX_GP3 3
`define BMX_SEL0 0
`define BMX_SEL1 1
`define BMX_SEL2 2
`define BMX_SEL3 3
`define BMX_D0 0
`define BMX_D1 1
`define BMX_D2 2
`define BMX_D3 3
`define BMX_DS_ONE 3'h1
`define BMX_DS_THREE 3'h3
`define BMX_DS_FOUR 3'h4
`define BMX_GIF_NONE 1'h0
`define BMX_GIF_ONE 1'h1
`endif

// [bmx_pkg.sv]
// types shared by the bridge mode pin multiplexer
`default_nettype none
package bmx_pkg;
    typedef logic [1:0] bmx_mode_t;
    typedef enum logic [1:0] {BMX_FN_NONE, BMX_FN_SPI_MASTER_FN, BMX_FN_SPI_SLAVE_FN, BMX_FN_I2C} bmx_fn_t;
    typedef enum logic [1:0] {BMX_W_SINGLE, BMX_W_DUAL, BMX_W_QUAD} bmx_width_t;
    typedef enum logic [1:0] {BMX_G3_GPIO, BMX_G3_WAKE, BMX_G3_IRQ} bmx_g3_t;
    typedef struct packed {
        logic out;
        logic oe;
    } bmx_pad_t;
    typedef struct packed {
        logic sck;
        logic [3:0] sel_n;
        logic [3:0] dout;
        logic [3:0] doe;
    } bmx_spi_master_fn_t;
endpackage
`default_nettype wire

// [bmx_pin_mux.sv]
// strap-selected mode and shared pin routing for the usb to spi/i2c bridge
// What this block does
// (R1) two straps, upper bit first, choose one of four modes
// (R2) strap changes only act after a reset
// (R3) mode fixes counts of data-stream and gpio interfaces
// (R4) spi master selectable in 00/11, always on for interface 0 in 01/10
// (R5) spi slave selectable in 00/11, disabled in 01/10
// (R6) spi master, spi slave and i2c exclude each other
// (R7) bus type and role are run-time inputs, not mode-set
// (R8) pin 0: gpio or i2c clock; in 01/10 master select 1
// (R9) pin 1: gpio or i2c data; in 01/10 master select 2
// (R10) pin 2: gpio or suspend; select 3 in mode 10; suspend in 11
// (R11) pin 3: gpio, wake or irq in 00/01; wake only in 10/11
// (R12) software gpio control blocked while pin has a special role
// (R13) spi clock drives as master, is input as slave
// (R14) miso: slave-to-master data single, bit 1 in dual/quad
// (R15) mosi: master-to-slave data single, bit 0 in dual/quad
// (R16) extra data pins carry bits 2 and 3 in quad only
// (R17) master offers slave-select 0 in every mode, 1 and 2 in 01/10, 3 in mode 10 only
// (R18) external logic holds slave-select input high in master role
// (R19) i2c pins only in modes 00/11 with i2c enabled
// (R20) i2c clock open-drain as master, input as slave; data open-drain
// (R21) charger detect output with selectable active level
// (R22) active-low reset clears all but gpio_blocked, which it sets, and re-samples straps
// (R23) straps latched at reset release, held until next reset
`include "bmx_consts.svh"
`default_nettype none
module bmx_pin_mux (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_strap_lo,
    input wire logic mode_strap_hi,
    input wire bmx_pkg::bmx_fn_t fn_req,
    input wire bmx_pkg::bmx_width_t spi_width,
    input wire logic i2c_is_master,
    input wire logic gp2_suspend_en,
    input wire bmx_pkg::bmx_g3_t gp3_role,
    input wire bmx_pkg::bmx_spi_master_fn_t spi_master_fn,
    input wire logic spi_slave_fn_dout,
    input wire logic spi_slave_fn_doe,
    input wire logic i2c_scl_low,
    input wire logic i2c_sda_low,
    input wire logic [3:0] gpio_sw_out,
    input wire logic [3:0] gpio_sw_oe,
    input wire logic suspend_status,
    input wire logic irq_req,
    input wire logic chg_port_detect,
    input wire logic chg_active_high,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic quad_data2_in,
    input wire logic quad_data3_in,
    input wire logic slave_sel_in,
    input wire logic [3:0] gp_in,
    output bmx_pkg::bmx_pad_t sck_pad,
    output bmx_pkg::bmx_pad_t mosi_pad,
    output bmx_pkg::bmx_pad_t miso_pad,
    output bmx_pkg::bmx_pad_t quad_data2,
    output bmx_pkg::bmx_pad_t quad_data3,
    output bmx_pkg::bmx_pad_t master_sel_out0,
    output logic [3:0] gp_out,
    output logic [3:0] gp_oe,
    output logic charger_detect_out,
    output logic [3:0] spi_master_fn_din,
    output logic spi_slave_fn_sck,
    output logic spi_slave_fn_din,
    output logic spi_slave_fn_sel_n,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    output logic [3:0] gpio_sw_in,
    output logic wake_in,
    output bmx_pkg::bmx_mode_t mode,
    output logic mode_valid,
    output logic [2:0] ds_count,
    output logic gpio_if_count,
    output bmx_pkg::bmx_fn_t fn_active,
    output logic [3:0] gpio_blocked
);
    import bmx_pkg::*;

    // modes 01 and 10 dedicate the spi pins to master use
    function automatic logic multi_mode(input bmx_mode_t m);
        return (m == `BMX_MODE_ONE) || (m == `BMX_MODE_TWO);
    endfunction

    // straps are caught on the first edge after release, never under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= `BMX_MODE_RST; // R22
            mode_valid <= 1'b0;
        end else if (!mode_valid) begin
            mode <= {mode_strap_hi, mode_strap_lo}; // R1 R23
            mode_valid <= 1'b1; // R2
        end
    end

    // interface counts follow the latched mode only
    always_comb begin
        unique case (mode)
            `BMX_MODE_ZERO: begin
                ds_count = `BMX_DS_ONE; // R3
                gpio_if_count = `BMX_GIF_ONE;
            end
            `BMX_MODE_ONE: begin
                ds_count = `BMX_DS_THREE; // R3
                gpio_if_count = `BMX_GIF_ONE;
            end
            `BMX_MODE_TWO: begin
                ds_count = `BMX_DS_FOUR; // R3
                gpio_if_count = `BMX_GIF_NONE;
            end
            `BMX_MODE_THREE: begin
                ds_count = `BMX_DS_ONE; // R3
                gpio_if_count = `BMX_GIF_NONE;
            end
        endcase
    end

    // one function at a time; until the straps are latched nothing is live
    always_comb begin
        if (!mode_valid) begin
            fn_active = BMX_FN_NONE;
        end else if (multi_mode(mode)) begin
            fn_active = BMX_FN_SPI_MASTER_FN; // R4 R5
        end else begin
            fn_active = fn_req; // R6 R7
        end
    end

    logic is_spi_master_fn;
    logic is_spi_slave_fn;
    logic is_i2c;
    logic quad;
    logic wide;
    assign is_spi_master_fn = (fn_active == BMX_FN_SPI_MASTER_FN);
    assign is_spi_slave_fn = (fn_active == BMX_FN_SPI_SLAVE_FN);
    assign is_i2c = (fn_active == BMX_FN_I2C); // R19
    assign quad = (spi_width == BMX_W_QUAD);
    assign wide = (spi_width != BMX_W_SINGLE);

    bmx_pad_t next_sck;
    bmx_pad_t next_mosi;
    bmx_pad_t next_miso;
    bmx_pad_t next_qd2;
    bmx_pad_t next_qd3;
    bmx_pad_t next_sel0;

    // spi pad directions by role and data width
    always_comb begin
        next_sck = '0;
        next_mosi = '0;
        next_miso = '0;
        next_qd2 = '0;
        next_qd3 = '0;
        next_sel0 = '0;
        if (is_spi_master_fn) begin
            next_sck = '{out: spi_master_fn.sck, oe: 1'b1}; // R13
            next_sel0 = '{out: spi_master_fn.sel_n[`BMX_SEL0], oe: 1'b1}; // R17
            if (wide) begin
                next_mosi = '{out: spi_master_fn.dout[`BMX_D0], oe: spi_master_fn.doe[`BMX_D0]}; // R15
                next_miso = '{out: spi_master_fn.dout[`BMX_D1], oe: spi_master_fn.doe[`BMX_D1]}; // R14
            end else begin
                next_mosi = '{out: spi_master_fn.dout[`BMX_D0], oe: 1'b1}; // R15
            end
            if (quad) begin
                next_qd2 = '{out: spi_master_fn.dout[`BMX_D2], oe: spi_master_fn.doe[`BMX_D2]}; // R16
                next_qd3 = '{out: spi_master_fn.dout[`BMX_D3], oe: spi_master_fn.doe[`BMX_D3]}; // R16
            end
        end else if (is_spi_slave_fn) begin
            next_miso = '{out: spi_slave_fn_dout, oe: spi_slave_fn_doe}; // R14
        end
    end

    logic [3:0] next_gp_out;
    logic [3:0] next_gp_oe;
    logic [3:0] next_blocked;

    // shared pins: special roles win, software control only on free pins
    always_comb begin
        next_gp_out = gpio_sw_out;
        next_gp_oe = gpio_sw_oe;
        next_blocked = '0;
        if (!mode_valid) begin
            next_gp_oe = '0;
            next_blocked = '1;
        end else begin
            unique case (mode)
                `BMX_MODE_ZERO, `BMX_MODE_THREE: begin
                    if (is_i2c || mode == `BMX_MODE_THREE) begin
                        next_blocked[`BMX_GP0] = 1'b1; // R8
                        next_blocked[`BMX_GP1] = 1'b1; // R9
                    end
                    if (gp2_suspend_en || mode == `BMX_MODE_THREE) begin
                        next_blocked[`BMX_GP2] = 1'b1; // R10
                    end
                    if (gp3_role != BMX_G3_GPIO || mode == `BMX_MODE_THREE) begin
                        next_blocked[`BMX_GP3] = 1'b1; // R11
                    end
                end
                `BMX_MODE_ONE: begin
                    next_blocked[`BMX_GP0] = 1'b1; // R8
                    next_blocked[`BMX_GP1] = 1'b1; // R9
                    next_blocked[`BMX_GP2] = gp2_suspend_en; // R10
                    next_blocked[`BMX_GP3] = (gp3_role != BMX_G3_GPIO); // R11
                end
                `BMX_MODE_TWO: begin
                    next_blocked = '1; // R10 R11
                end
            endcase
            // blocked pins lose the software drive before roles are applied
            next_gp_out = gpio_sw_out & ~next_blocked; // R12
            next_gp_oe = gpio_sw_oe & ~next_blocked; // R12
            if (multi_mode(mode)) begin
                next_gp_out[`BMX_GP0] = spi_master_fn.sel_n[`BMX_SEL1]; // R8 R17
                next_gp_oe[`BMX_GP0] = 1'b1;
                next_gp_out[`BMX_GP1] = spi_master_fn.sel_n[`BMX_SEL2]; // R9 R17
                next_gp_oe[`BMX_GP1] = 1'b1;
            end else if (is_i2c) begin
                // open drain: pull low by enable, never drive high
                next_gp_oe[`BMX_GP0] = i2c_is_master & i2c_scl_low; // R20
                next_gp_oe[`BMX_GP1] = i2c_sda_low; // R20
            end
            if (mode == `BMX_MODE_TWO) begin
                next_gp_out[`BMX_GP2] = spi_master_fn.sel_n[`BMX_SEL3]; // R10 R17
                next_gp_oe[`BMX_GP2] = 1'b1;
            end else if (next_blocked[`BMX_GP2]) begin
                next_gp_out[`BMX_GP2] = suspend_status; // R10
                next_gp_oe[`BMX_GP2] = 1'b1;
            end
            if (!multi_mode(mode) && mode != `BMX_MODE_THREE) begin
                if (mode == `BMX_MODE_ZERO && gp3_role == BMX_G3_IRQ) begin
                    next_gp_out[`BMX_GP3] = irq_req; // R11
                    next_gp_oe[`BMX_GP3] = 1'b1;
                end
            end
            if (mode == `BMX_MODE_ONE && gp3_role == BMX_G3_IRQ) begin
                next_gp_out[`BMX_GP3] = irq_req; // R11
                next_gp_oe[`BMX_GP3] = 1'b1;
            end
        end
    end

    // open-drain pins carry a low level whenever enabled
    logic [3:0] od_zero;
    assign od_zero = {2'h0, is_i2c && !multi_mode(mode), is_i2c && !multi_mode(mode)};

    // pad outputs are registered so pins never glitch on a role change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_pad <= '0;
            mosi_pad <= '0;
            miso_pad <= '0;
            quad_data2 <= '0;
            quad_data3 <= '0;
            master_sel_out0 <= '0;
        end else begin
            sck_pad <= next_sck; // R13
            mosi_pad <= next_mosi;
            miso_pad <= next_miso;
            quad_data2 <= next_qd2;
            quad_data3 <= next_qd3;
            master_sel_out0 <= next_sel0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gp_out <= '0;
            gp_oe <= '0;
            gpio_blocked <= '1;
        end else begin
            gp_out <= next_gp_out & ~od_zero; // R20
            gp_oe <= next_gp_oe;
            gpio_blocked <= next_blocked; // R12
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_detect_out <= 1'b0;
        end else begin
            charger_detect_out <= chg_port_detect ~^ chg_active_high; // R21
        end
    end

    // inputs back to the cores; unused returns sit at idle levels
    always_comb begin
        spi_master_fn_din = '0;
        if (is_spi_master_fn) begin
            spi_master_fn_din[`BMX_D0] = wide ? mosi_in : 1'b0; // R15
            spi_master_fn_din[`BMX_D1] = miso_in; // R14
            spi_master_fn_din[`BMX_D2] = quad ? quad_data2_in : 1'b0; // R16
            spi_master_fn_din[`BMX_D3] = quad ? quad_data3_in : 1'b0; // R16
        end
    end

    // the slave-select input is ignored as master; board keeps it high
    assign spi_slave_fn_sel_n = is_spi_slave_fn ? slave_sel_in : 1'b1; // R18
    assign spi_slave_fn_sck = is_spi_slave_fn ? sck_in : 1'b0; // R13
    assign spi_slave_fn_din = is_spi_slave_fn ? mosi_in : 1'b0; // R15
    assign i2c_scl_in = is_i2c ? gp_in[`BMX_GP0] : 1'b1; // R20
    assign i2c_sda_in = is_i2c ? gp_in[`BMX_GP1] : 1'b1; // R20
    assign gpio_sw_in = gp_in & ~gpio_blocked; // R12
    // modes 10/11 give pin 3 to wake alone; in 00/01 only when its role asks for it
    assign wake_in = mode_valid && (mode == `BMX_MODE_TWO || mode == `BMX_MODE_THREE
                     || gp3_role == BMX_G3_WAKE) && gp_in[`BMX_GP3]; // R11
endmodule
`default_nettype wire

// [bmx_pin_mux_assertions.sv]
// checker for the bridge mode pin multiplexer, bound to its ports
`include "bmx_consts.svh"
`default_nettype none
module bmx_pin_mux_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_strap_lo,
    input wire logic mode_strap_hi,
    input wire bmx_pkg::bmx_fn_t fn_req,
    input wire logic i2c_is_master,
    input wire bmx_pkg::bmx_spi_master_fn_t spi_master_fn,
    input wire logic i2c_scl_low,
    input wire logic chg_port_detect,
    input wire logic chg_active_high,
    input wire bmx_pkg::bmx_pad_t sck_pad,
    input wire logic [3:0] gp_out,
    input wire logic [3:0] gp_oe,
    input wire logic charger_detect_out,
    input wire bmx_pkg::bmx_mode_t mode,
    input wire logic mode_valid,
    input wire logic [2:0] ds_count,
    input wire logic gpio_if_count,
    input wire bmx_pkg::bmx_fn_t fn_active,
    input wire logic [3:0] gpio_blocked
);
    import bmx_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // registered outputs only settle one edge after the mode latch
    sequence s_up;
        mode_valid && $past(mode_valid);
    endsequence
    sequence s_fixed;
        s_up ##0 (mode == 2'h1 || mode == 2'h2);
    endsequence
    a_mode_latch: assert property ($rose(mode_valid) |->
        mode == {$past(mode_strap_hi), $past(mode_strap_lo)}) else $error("mode latch wrong");
    a_mode_held: assert property (s_up |-> $stable(mode)) else $error("mode moved");
    a_if_count: assert property (s_up |-> gpio_if_count == !mode[1] && ds_count ==
        (mode == 2'h1 ? 3'h3 : mode == 2'h2 ? 3'h4 : 3'h1)) else $error("counts wrong");
    a_fn_forced: assert property (s_fixed |-> fn_active == BMX_FN_SPI_MASTER_FN)
        else $error("fn not forced");
    a_fn_follow: assert property (s_up ##0 (mode[0] == mode[1]) |->
        fn_active == fn_req) else $error("fn not followed");
    a_pins_blocked: assert property (s_up |-> (mode == 2'h0 || &gpio_blocked[1:0]) &&
        (!mode[1] || &gpio_blocked)) else $error("pin not blocked");
    a_sel_route: assert property (s_fixed |-> gp_oe[1:0] == 2'h3 &&
        gp_out[1:0] == $past(spi_master_fn.sel_n[2:1])) else $error("select route wrong");
    a_sel_three: assert property (s_up ##0 (mode == 2'h2) |-> gp_oe[2] &&
        gp_out[2] == $past(spi_master_fn.sel_n[3])) else $error("select 3 wrong");
    a_sck_master: assert property (s_fixed |-> sck_pad.oe &&
        sck_pad.out == $past(spi_master_fn.sck)) else $error("sck not driven");
    a_sck_slave: assert property (s_up ##0 ($past(fn_req) == BMX_FN_SPI_SLAVE_FN &&
        mode[0] == mode[1]) |-> !sck_pad.oe) else $error("sck driven as slave");
    a_scl_drain: assert property (s_up ##0 (mode == 2'h3 && $past(fn_req) == BMX_FN_I2C &&
        $past(i2c_is_master)) |-> gp_oe[0] == $past(i2c_scl_low) && !gp_out[0])
        else $error("scl not open drain");
    a_chg_level: assert property (s_up |->
        charger_detect_out == ($past(chg_port_detect) ~^ $past(chg_active_high)))
        else $error("charger level wrong");
endmodule
bind bmx_pin_mux bmx_pin_mux_assertions u_bmx_pin_mux_assertions (.clk, .rst_n,
    .mode_strap_lo, .mode_strap_hi, .fn_req, .i2c_is_master, .spi_master_fn, .i2c_scl_low,
    .chg_port_detect, .chg_active_high, .sck_pad, .gp_out, .gp_oe, .charger_detect_out,
    .mode, .mode_valid, .ds_count, .gpio_if_count, .fn_active, .gpio_blocked);
`default_nettype wire

// [bmx_periph_model.sv]
// far-side spi/i2c peripheral: resolves the shared lines back to the pads
`default_nettype none
module bmx_periph_model (
    input wire logic clk,
    input wire logic host_master,
    input wire logic [3:0] ext_d,
    input wire bmx_pkg::bmx_pad_t sck_pad,
    input wire bmx_pkg::bmx_pad_t mosi_pad,
    input wire bmx_pkg::bmx_pad_t miso_pad,
    input wire logic [3:0] gp_out,
    input wire logic [3:0] gp_oe,
    output logic sck_in,
    output logic mosi_in,
    output logic miso_in,
    output logic slave_sel_in,
    output logic [3:0] gp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;
    // undriven pins 2/3 toggle, so a stale value never passes; undriven spi lines read ext_d
    always @(posedge clk) flip <= ~flip;
    assign sck_in = sck_pad.oe ? sck_pad.out : ext_d[0];
    assign mosi_in = mosi_pad.oe ? mosi_pad.out : ext_d[1];
    assign miso_in = miso_pad.oe ? miso_pad.out : ext_d[2];
    assign slave_sel_in = host_master | ext_d[3];
    // pins 0/1 carry the i2c pull-ups
    assign gp_in[1:0] = {gp_oe[1] ? gp_out[1] : 1'b1, gp_oe[0] ? gp_out[0] : 1'b1};
    assign gp_in[3:2] = {gp_oe[3] ? gp_out[3] : flip, gp_oe[2] ? gp_out[2] : ~flip};
endmodule
`default_nettype wire

// [tb_bmx_pin_mux.sv]
// self-checking bench for the bridge mode pin multiplexer
`default_nettype none
module tb_bmx_pin_mux;
    import bmx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, mode_strap_lo = 1'b0, mode_strap_hi = 1'b0;
    logic i2c_is_master = 1'b1, gp2_suspend_en = 1'b0, i2c_scl_low = 1'b1, i2c_sda_low = 1'b0;
    logic chg_port_detect = 1'b0, chg_active_high = 1'b0, suspend_status = 1'b1;
    logic irq_req = 1'b0, spi_slave_fn_dout = 1'b0, spi_slave_fn_doe = 1'b0;
    logic [3:0] gpio_sw_out = 4'hC, gpio_sw_oe = 4'hC, ext_d = 4'h7;
    logic wake_in, spi_slave_fn_sel_n, spi_slave_fn_din, i2c_scl_in, i2c_sda_in;
    logic [3:0] spi_master_fn_din;
    bmx_fn_t fn_req = BMX_FN_I2C;
    bmx_width_t spi_width = BMX_W_QUAD;
    bmx_g3_t gp3_role = BMX_G3_GPIO;
    bmx_spi_master_fn_t spi_master_fn = '{sck: 1'b1, sel_n: 4'h5, dout: 4'h9, doe: 4'hF};
    bmx_pad_t sck_pad, mosi_pad, miso_pad, q2, q3, master_sel_out0;
    logic [3:0] gp_out, gp_oe, gp_in, gpio_sw_in;
    logic sck_in, mosi_in, miso_in, slave_sel_in, charger_detect_out, spi_slave_fn_sck, mode_valid;
    logic gpio_if_count;
    logic [2:0] ds_count;
    bmx_mode_t mode;
    bmx_fn_t fn_active;
    logic [3:0] gpio_blocked;
    int n_fail = 0;
    int checks_done = 0;
    logic [3:0] oe_t [4] = '{4'hD, 4'hF, 4'h7, 4'h5};
    logic [3:0] out_t [4] = '{4'hC, 4'hE, 4'h2, 4'h4};
    logic [3:0] msk_t [4] = '{4'hF, 4'hF, 4'h7, 4'h7};
    logic [2:0] ds_t [4] = '{3'h1, 3'h3, 3'h4, 3'h1};
    bmx_pin_mux u_bmx_pin_mux (.clk, .rst_n, .mode_strap_lo, .mode_strap_hi, .fn_req,
        .spi_width, .i2c_is_master, .gp2_suspend_en, .gp3_role, .spi_master_fn, .spi_slave_fn_dout,
        .spi_slave_fn_doe, .i2c_scl_low, .i2c_sda_low, .gpio_sw_out, .gpio_sw_oe,
        .suspend_status, .irq_req, .chg_port_detect, .chg_active_high, .sck_in, .mosi_in,
        .miso_in, .quad_data2_in(1'b0), .quad_data3_in(1'b0), .slave_sel_in, .gp_in,
        .sck_pad, .mosi_pad, .miso_pad, .quad_data2(q2), .quad_data3(q3), .master_sel_out0,
        .gp_out, .gp_oe, .charger_detect_out, .spi_master_fn_din, .spi_slave_fn_sck, .spi_slave_fn_din,
        .spi_slave_fn_sel_n, .i2c_scl_in, .i2c_sda_in, .gpio_sw_in, .wake_in, .mode,
        .mode_valid, .ds_count, .gpio_if_count, .fn_active, .gpio_blocked);
    bmx_periph_model u_bmx_periph_model (.clk, .host_master(fn_active == BMX_FN_SPI_MASTER_FN),
        .ext_d, .sck_pad, .mosi_pad, .miso_pad, .gp_out, .gp_oe, .sck_in, .mosi_in,
        .miso_in, .slave_sel_in, .gp_in);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            step(1);
            rst_n = 1'b0;
            {mode_strap_hi, mode_strap_lo} = m[1:0];
            step(4);
            rst_n = 1'b1;
            step(3);
            chk("mode", m, mode);
            chk("ds_count", ds_t[m], ds_count);
            chk("gpio_if", m < 2, gpio_if_count);
            chk("fn", (m == 1 || m == 2) ? BMX_FN_SPI_MASTER_FN : BMX_FN_I2C, fn_active);
            chk("blocked", m > 1 ? 4'hF : 4'h3, gpio_blocked);
            chk("gp_oe", oe_t[m] & msk_t[m], gp_oe & msk_t[m]);
            chk("gp_out", out_t[m] & msk_t[m], gp_out & msk_t[m]);
            chk("pin3_oe", m < 2, gp_oe[3]);
            chk("sck_sel", {2{m == 1 || m == 2}}, {sck_pad.oe, master_sel_out0.oe});
            chk("sw_in", 2'h0, gpio_sw_in[1:0]);
            chk("i2c_in", (m == 0 || m == 3) ? 2'h1 : 2'h3, {i2c_scl_in, i2c_sda_in});
            chk("wake", m > 1 && gp_in[3], wake_in);
        end
        {mode_strap_hi, mode_strap_lo} = 2'h1;
        step(3);
        chk("mode_kept", 2'h3, mode);
        fn_req = BMX_FN_SPI_SLAVE_FN;
        spi_slave_fn_dout = 1'b1;
        spi_slave_fn_doe = 1'b1;
        step(2);
        chk("fn_slave", BMX_FN_SPI_SLAVE_FN, fn_active);
        chk("sck_slave", {1'b0, ext_d[0]}, {sck_pad.oe, spi_slave_fn_sck});
        chk("slave_miso", 2'h3, {miso_pad.out, miso_pad.oe});
        chk("slave_sel_din", 2'h1, {spi_slave_fn_sel_n, spi_slave_fn_din});
        fn_req = BMX_FN_SPI_MASTER_FN;
        step(2);
        chk("quad_out", 4'h9, {q3.out, q2.out, miso_pad.out, mosi_pad.out});
        chk("quad_oe", 4'hF, {q3.oe, q2.oe, miso_pad.oe, mosi_pad.oe});
        chk("pin0_master", 2'h1, {gp_oe[0], gpio_blocked[0]});
        chk("sel_in_master", 2'h3, {spi_slave_fn_sel_n, slave_sel_in});
        spi_width = BMX_W_SINGLE;
        step(2);
        chk("single_oe", 4'h1, {q3.oe, q2.oe, miso_pad.oe, mosi_pad.oe});
        for (int c = 0; c < 4; c++) begin
            {chg_port_detect, chg_active_high} = c[1:0];
            step(2);
            chk("charger", c[0] ? c[1] : !c[1], charger_detect_out);
        end
        // fifth reset in mid-run: new straps must take effect now
        rst_n = 1'b0;
        {mode_strap_hi, mode_strap_lo} = 2'h1;
        gp3_role = BMX_G3_WAKE;
        spi_width = BMX_W_DUAL;
        step(2);
        rst_n = 1'b1;
        step(3);
        chk("mode_again", 2'h1, mode);
        chk("dual_oe", 3'h3, {q2.oe, miso_pad.oe, mosi_pad.oe});
        chk("dual_din", 4'h1, spi_master_fn_din);
        repeat (2) begin
            chk("wake_one", {1'b0, gp_in[3]}, {gp_oe[3], wake_in});
            step(1);
        end
        gp3_role = BMX_G3_IRQ;
        gp2_suspend_en = 1'b1;
        irq_req = 1'b1;
        step(2);
        chk("pin3_irq", 3'h7, {gpio_blocked[3], gp_oe[3], gp_out[3]});
        chk("pin2_suspend_status_out", 3'h7, {gpio_blocked[2], gp_oe[2], gp_out[2]});
        rst_n = 1'b0;
        #1;
        chk("reset", 5'h00, {mode_valid, gp_oe});
        tally_and_finish();
    end
    initial begin
        #20us;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
